/* rtl/ebc_ctrl.sv */
// emulation control with two breakpoint slots, halt factors and tracepoint
// assumes the emulation core and register master are on clk_sys;
// abort, fatal, timeout and user ready come from pins
`timescale 1ns/1ps

// Notes on behaviour
// [R1] two breakpoint slots, each halting emulation when enabled and matching
// [R2] program load resets halt factor register to no-halt
// [R3] program load sets both slots all don't-care and disabled
// [R4] start runs from code segment base and instruction offset
// [R5] emulation_active_out is high while emulation runs
// [R6] emulation runs until abort, fatal error, or enabled halt factor
// [R7] abort finishes current instruction; registers then hold next address
// [R8] optional start address loads segment and offset first; code zeroes the segment and takes the offset from bits 31:16
// [R9] no-halt start option disables all halt factors
// [R10] start with match conditions loads and enables breakpoint slots; code loads only slot 0 and only enables slot 1
// [R11] slot accepts execution or non-execution type condition; code supports execution conditions only
// [R12] execution condition is 20 address bits with don't-care, plus qualifier; code has no qualifier field
// [R13] match checked when byte leaves the queue for execution
// [R14] match when cared bits of executed byte address equal slot
// [R15] full address is segment times sixteen plus displacement
// [R16] single constant address reduced modulo 65536
// [R17] masked address loads don't-care bits to match a range
// [R18] single condition loads first slot, second slot unchanged
// [R19] access-timeout setting halts with error or is ignored
// [R20] setting enables user ready input for access termination
// [R21] tracepoint slot match starts or stops trace collection
// [R22] breakpoint hit finishes instruction, halts, clears active, flags cause
module ebc_ctrl
    import ebc_pkg::*;
#(
    parameter int AW = ADDR_W
)
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic [ebc_pkg::REG_AW-1:0] reg_addr,
    input wire logic [ebc_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [ebc_pkg::DATA_W-1:0] reg_rdata,
    input wire logic [AW-1:0] exec_addr,
    input wire logic exec_strobe,
    input wire logic instr_end,
    input wire logic [15:0] next_seg,
    input wire logic [15:0] next_ofs,
    input wire logic abort_pin,
    input wire logic fatal_pin,
    input wire logic timeout_pin,
    input wire logic user_ready_pin,
    output logic core_run,
    output logic [15:0] core_seg,
    output logic [15:0] core_ofs,
    output logic core_start,
    output logic ready_use,
    output logic emulation_active_out,
    output logic trace_collect
);
    import ebc_pkg::*;

    ebc_state_t state_r, state_nxt;
    logic [1:0] abort_s, fatal_s, tmo_s, rdy_s;
    logic [15:0] code_seg_r, instr_offset_r;
    logic [AW-1:0] bp0_val_r, bp0_care_r, bp1_val_r, bp1_care_r;
    logic [AW-1:0] trc_val_r, trc_care_r;
    logic [HF_W-1:0] halt_factor_register_r;
    logic [2:0] cfg_r;
    logic [ST_W-1:0] status_r;
    logic [DATA_W-1:0] rdata_r;
    logic start_pulse_r;
    logic trace_r;
    logic hit0, hit1, hit_trc;
    logic bp0_halt, bp1_halt, tmo_halt, stop_req;
    logic wr_ctrl, do_load, do_go, do_abort, cause_clr;
    logic [AW-1:0] start_full, short_addr;
    logic [DATA_W-1:0] rd_mux;
    logic pend_abort_r, pend_bp0_r, pend_bp1_r, pend_tmo_r;

    // pin synchronisers
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            abort_s <= 2'h0;
            fatal_s <= 2'h0;
            tmo_s <= 2'h0;
            rdy_s <= 2'h0;
        end
        else if (clk_en)
        begin
            abort_s <= {abort_s[0], abort_pin};
            fatal_s <= {fatal_s[0], fatal_pin};
            tmo_s <= {tmo_s[0], timeout_pin};
            rdy_s <= {rdy_s[0], user_ready_pin};
        end
    end

    // control decode
    assign wr_ctrl = reg_wr && (reg_addr == OFF_CTRL);
    assign do_load = wr_ctrl && reg_wdata[CTRL_LOAD];
    assign do_go = wr_ctrl && reg_wdata[CTRL_GO] && (state_r == EBC_IDLE);
    assign do_abort = (wr_ctrl && reg_wdata[CTRL_ABORT]) || abort_s[1];
    assign cause_clr = wr_ctrl && reg_wdata[CTRL_CLR_CAUSE];
    // [R15] segment times sixteen plus offset
    assign start_full = AW'({4'h0, code_seg_r} << SEG_SHIFT) + AW'(instr_offset_r);
    // [R16] short constant modulo 65536
    assign short_addr = AW'(reg_wdata[SHORT_W-1:0]);

    // breakpoint and trace comparators
    // [R1] two slots
    ebc_match #(.AW(AW)) u_bp0 (
        .value(bp0_val_r), .care(bp0_care_r), .exec_addr(exec_addr),
        .exec_strobe(exec_strobe), .hit(hit0)
    );
    ebc_match #(.AW(AW)) u_bp1 (
        .value(bp1_val_r), .care(bp1_care_r), .exec_addr(exec_addr),
        .exec_strobe(exec_strobe), .hit(hit1)
    );
    ebc_match #(.AW(AW)) u_trc (
        .value(trc_val_r), .care(trc_care_r), .exec_addr(exec_addr),
        .exec_strobe(exec_strobe), .hit(hit_trc)
    );

    // [R6] halt sources gated by factors
    assign bp0_halt = hit0 && halt_factor_register_r[HF_BP0];
    assign bp1_halt = hit1 && halt_factor_register_r[HF_BP1];
    // [R19] timeout halts only when set
    assign tmo_halt = tmo_s[1] && cfg_r[CFG_TIMEOUT_HALT];
    assign stop_req = do_abort || bp0_halt || bp1_halt || tmo_halt
        || pend_abort_r || pend_bp0_r || pend_bp1_r || pend_tmo_r;

    // run state machine
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            EBC_IDLE:
            begin
                if (do_go)
                    state_nxt = EBC_RUN;
            end
            EBC_RUN:
            begin
                // [R6] fatal stops at once
                if (fatal_s[1])
                    state_nxt = EBC_IDLE;
                // [R7] finish instruction first
                else if (stop_req)
                    state_nxt = instr_end ? EBC_IDLE : EBC_FINISH;
            end
            EBC_FINISH:
            begin
                if (instr_end || fatal_s[1])
                    state_nxt = EBC_IDLE;
            end
            default: state_nxt = EBC_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            state_r <= EBC_IDLE;
        else if (clk_en)
            state_r <= state_nxt;
    end

    // latched stop causes while finishing
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pend_abort_r <= 1'b0;
            pend_bp0_r <= 1'b0;
            pend_bp1_r <= 1'b0;
            pend_tmo_r <= 1'b0;
        end
        else if (clk_en)
        begin
            pend_abort_r <= (state_nxt != EBC_IDLE) && (pend_abort_r || do_abort);
            pend_bp0_r <= (state_nxt != EBC_IDLE) && (pend_bp0_r || bp0_halt);
            pend_bp1_r <= (state_nxt != EBC_IDLE) && (pend_bp1_r || bp1_halt);
            pend_tmo_r <= (state_nxt != EBC_IDLE) && (pend_tmo_r || tmo_halt);
        end
    end

    // [R22] halt cause flags, set wins over clear
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            status_r <= '0;
        else if (clk_en)
        begin
            if (cause_clr || do_go)
                status_r[ST_CAUSE_TIMEOUT:ST_CAUSE_ABORT] <= '0;
            if (state_r != EBC_IDLE && state_nxt == EBC_IDLE)
            begin
                if (pend_abort_r || do_abort)
                    status_r[ST_CAUSE_ABORT] <= 1'b1;
                if (fatal_s[1])
                    status_r[ST_CAUSE_FATAL] <= 1'b1;
                if (pend_bp0_r || bp0_halt)
                    status_r[ST_CAUSE_BP0] <= 1'b1;
                if (pend_bp1_r || bp1_halt)
                    status_r[ST_CAUSE_BP1] <= 1'b1;
                if (pend_tmo_r || tmo_halt)
                    status_r[ST_CAUSE_TIMEOUT] <= 1'b1;
            end
            status_r[ST_ACTIVE] <= (state_nxt != EBC_IDLE);
            status_r[ST_TRACING] <= trace_r;
        end
    end

    // start address registers
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            code_seg_r <= WORD_ZERO;
            instr_offset_r <= WORD_ZERO;
        end
        else if (clk_en)
        begin
            // [R7] hold next instruction on halt
            if (state_r != EBC_IDLE && state_nxt == EBC_IDLE)
            begin
                code_seg_r <= next_seg;
                instr_offset_r <= next_ofs;
            end
            // [R8] start point from command
            else if (wr_ctrl && reg_wdata[CTRL_FROM] && state_r == EBC_IDLE)
            begin
                code_seg_r <= WORD_ZERO;
                instr_offset_r <= reg_wdata[31:16];
            end
            else if (reg_wr && reg_addr == OFF_CODE_SEG && state_r == EBC_IDLE)
                code_seg_r <= reg_wdata[15:0];
            else if (reg_wr && reg_addr == OFF_INSTR_OFS && state_r == EBC_IDLE)
                instr_offset_r <= reg_wdata[15:0];
        end
    end

    // breakpoint slots and halt factors
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bp0_val_r <= ADDR_ZERO;
            bp0_care_r <= CARE_NONE;
            bp1_val_r <= ADDR_ZERO;
            bp1_care_r <= CARE_NONE;
            halt_factor_register_r <= HF_NONE;
        end
        else if (clk_en)
        begin
            if (do_load)
            begin
                // [R2] no-halt after load
                halt_factor_register_r <= HF_NONE;
                // [R3] all don't-care, disabled
                bp0_care_r <= CARE_NONE;
                bp1_care_r <= CARE_NONE;
            end
            else if (do_go && reg_wdata[CTRL_NO_HALT])
                // [R9] no-halt start
                halt_factor_register_r <= HF_NONE;
            else if (do_go)
            begin
                // [R10] load and enable slot 0, only enable slot 1
                // [R18] one condition goes to first slot
                if (reg_wdata[CTRL_SET_BP0])
                begin
                    bp0_val_r <= reg_wdata[CTRL_SHORT] ? short_addr : start_full;
                    bp0_care_r <= CARE_ALL;
                    halt_factor_register_r[HF_BP0] <= 1'b1;
                end
                if (reg_wdata[CTRL_SET_BP1])
                    halt_factor_register_r[HF_BP1] <= 1'b1;
            end
            else if (reg_wr && state_r == EBC_IDLE)
            begin
                // [R11] [R12] execution value and care masks
                // [R17] masked address as care bits
                case (reg_addr)
                    OFF_BP0_VAL: bp0_val_r <= reg_wdata[AW-1:0];
                    OFF_BP0_CARE: bp0_care_r <= reg_wdata[AW-1:0];
                    OFF_BP1_VAL: bp1_val_r <= reg_wdata[AW-1:0];
                    OFF_BP1_CARE: bp1_care_r <= reg_wdata[AW-1:0];
                    OFF_HALT_FACTOR: halt_factor_register_r <= reg_wdata[HF_W-1:0];
                    default: ;
                endcase
            end
        end
    end

    // configuration and tracepoint
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cfg_r <= 3'h0;
            trc_val_r <= ADDR_ZERO;
            trc_care_r <= CARE_NONE;
        end
        else if (clk_en && reg_wr)
        begin
            if (reg_addr == OFF_CONFIG)
                cfg_r <= reg_wdata[2:0];
            if (reg_addr == OFF_TRACE_VAL)
                trc_val_r <= reg_wdata[AW-1:0];
            if (reg_addr == OFF_TRACE_CARE)
                trc_care_r <= reg_wdata[AW-1:0];
        end
    end

    // [R21] tracepoint toggles collection
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            trace_r <= 1'b0;
        else if (clk_en)
        begin
            if (!cfg_r[CFG_TRACE_EN])
                trace_r <= 1'b0;
            else if (hit_trc && state_r != EBC_IDLE)
                trace_r <= !trace_r;
        end
    end

    // start pulse to the core
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            start_pulse_r <= 1'b0;
        else if (clk_en)
            start_pulse_r <= do_go;
    end

    // read path
    assign rd_mux =
        (reg_addr == OFF_STATUS) ? DATA_W'(status_r) :
        (reg_addr == OFF_CODE_SEG) ? DATA_W'(code_seg_r) :
        (reg_addr == OFF_INSTR_OFS) ? DATA_W'(instr_offset_r) :
        (reg_addr == OFF_BP0_VAL) ? DATA_W'(bp0_val_r) :
        (reg_addr == OFF_BP0_CARE) ? DATA_W'(bp0_care_r) :
        (reg_addr == OFF_BP1_VAL) ? DATA_W'(bp1_val_r) :
        (reg_addr == OFF_BP1_CARE) ? DATA_W'(bp1_care_r) :
        (reg_addr == OFF_HALT_FACTOR) ? DATA_W'(halt_factor_register_r) :
        (reg_addr == OFF_CONFIG) ? DATA_W'(cfg_r) :
        (reg_addr == OFF_TRACE_VAL) ? DATA_W'(trc_val_r) :
        (reg_addr == OFF_TRACE_CARE) ? DATA_W'(trc_care_r) :
        (reg_addr == OFF_START_ADDR) ? DATA_W'(start_full) : '0;

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            rdata_r <= '0;
        else if (clk_en && reg_rd)
            rdata_r <= rd_mux;
    end

    assign reg_rdata = rdata_r;
    // [R4] core starts at segment and offset
    assign core_seg = code_seg_r;
    assign core_ofs = instr_offset_r;
    assign core_start = start_pulse_r;
    assign core_run = (state_r != EBC_IDLE);
    // [R5] active while running
    assign emulation_active_out = status_r[ST_ACTIVE];
    // [R20] user ready gating
    assign ready_use = cfg_r[CFG_READY_EN] ? rdy_s[1] : 1'b1;
    assign trace_collect = trace_r;
endmodule

/* rtl/ebc_match.sv */
// one breakpoint comparator with per-bit don't-care
// assumes execution address and strobe are on clk_sys
`timescale 1ns/1ps
module ebc_match
    import ebc_pkg::*;
#(
    parameter int AW = ADDR_W
)
(
    input wire logic [AW-1:0] value,
    input wire logic [AW-1:0] care,
    input wire logic [AW-1:0] exec_addr,
    input wire logic exec_strobe,
    output logic hit
);
    logic [AW-1:0] bit_ok;
    genvar i;
    // [R14] compare cared bits
    generate
        for (i = 0; i < AW; i++)
        begin : g_bit
            assign bit_ok[i] = !care[i] || (value[i] == exec_addr[i]);
        end
    endgenerate
    // [R13] only on executed byte
    assign hit = exec_strobe && (&bit_ok);
endmodule

/* rtl/ebc_pkg.sv */
// constants, field layouts and states of the emulation breakpoint control
// shared by the control block and its breakpoint comparator
package ebc_pkg;
    localparam int ADDR_W = 20;
    localparam int DATA_W = 32;
    localparam int REG_AW = 4;
    localparam logic [REG_AW-1:0] OFF_CTRL = 4'h0;
    localparam logic [REG_AW-1:0] OFF_STATUS = 4'h1;
    localparam logic [REG_AW-1:0] OFF_CODE_SEG = 4'h2;
    localparam logic [REG_AW-1:0] OFF_INSTR_OFS = 4'h3;
    localparam logic [REG_AW-1:0] OFF_BP0_VAL = 4'h4;
    localparam logic [REG_AW-1:0] OFF_BP0_CARE = 4'h5;
    localparam logic [REG_AW-1:0] OFF_BP1_VAL = 4'h6;
    localparam logic [REG_AW-1:0] OFF_BP1_CARE = 4'h7;
    localparam logic [REG_AW-1:0] OFF_HALT_FACTOR = 4'h8;
    localparam logic [REG_AW-1:0] OFF_CONFIG = 4'h9;
    localparam logic [REG_AW-1:0] OFF_TRACE_VAL = 4'hA;
    localparam logic [REG_AW-1:0] OFF_TRACE_CARE = 4'hB;
    localparam logic [REG_AW-1:0] OFF_START_ADDR = 4'hC;
    // control register bits (write pulses)
    localparam int CTRL_LOAD = 0;
    localparam int CTRL_GO = 1;
    localparam int CTRL_ABORT = 2;
    localparam int CTRL_FROM = 3;
    localparam int CTRL_NO_HALT = 4;
    localparam int CTRL_SET_BP0 = 5;
    localparam int CTRL_SET_BP1 = 6;
    localparam int CTRL_SHORT = 7;
    localparam int CTRL_CLR_CAUSE = 8;
    // halt factor bits
    localparam int HF_BP0 = 0;
    localparam int HF_BP1 = 1;
    localparam int HF_W = 2;
    localparam logic [HF_W-1:0] HF_NONE = 2'h0;
    // config bits
    localparam int CFG_TIMEOUT_HALT = 0;
    localparam int CFG_READY_EN = 1;
    localparam int CFG_TRACE_EN = 2;
    // status bits
    localparam int ST_ACTIVE = 0;
    localparam int ST_CAUSE_ABORT = 1;
    localparam int ST_CAUSE_FATAL = 2;
    localparam int ST_CAUSE_BP0 = 3;
    localparam int ST_CAUSE_BP1 = 4;
    localparam int ST_CAUSE_TIMEOUT = 5;
    localparam int ST_TRACING = 6;
    localparam int ST_W = 7;
    localparam logic [ADDR_W-1:0] CARE_NONE = 20'h00000;
    localparam logic [ADDR_W-1:0] CARE_ALL = 20'hFFFFF;
    localparam logic [ADDR_W-1:0] ADDR_ZERO = 20'h00000;
    localparam logic [15:0] WORD_ZERO = 16'h0000;
    localparam int SEG_SHIFT = 4;
    localparam int SHORT_W = 16;
    typedef enum logic [1:0] {EBC_IDLE, EBC_RUN, EBC_FINISH} ebc_state_t;
endpackage

/* verif/ebc_core_model.sv */
// behavioural emulation core: one executed byte a cycle
// assumes two-byte instructions from an even offset
`timescale 1ns/1ps
module ebc_core_model
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic core_run,
    input wire logic core_start,
    input wire logic [15:0] core_seg,
    input wire logic [15:0] core_ofs,
    output logic [19:0] exec_addr,
    output logic exec_strobe,
    output logic instr_end,
    output logic [15:0] next_seg,
    output logic [15:0] next_ofs
);
    logic [15:0] ofs_r;
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ofs_r <= 16'h0000;
            exec_addr <= 20'h00000;
            exec_strobe <= 1'b0;
            instr_end <= 1'b0;
            next_seg <= 16'h0000;
            next_ofs <= 16'h0000;
        end
        else if (core_start)
        begin
            ofs_r <= core_ofs;
            next_seg <= core_seg;
        end
        else if (core_run)
        begin
            exec_addr <= {core_seg, 4'h0} + {4'h0, ofs_r};
            exec_strobe <= 1'b1;
            instr_end <= ofs_r[0];
            ofs_r <= ofs_r + 16'h0001;
            if (ofs_r[0])
                next_ofs <= ofs_r + 16'h0001;
        end
        else
        begin
            // idle bus inverts every bit of the last address each cycle
            exec_addr <= ~exec_addr;
            exec_strobe <= 1'b0;
            instr_end <= 1'b0;
        end
    end
endmodule

/* verif/ebc_ctrl_assertions.sv */
// port checks of the emulation control
// assumes bind onto ebc_ctrl from the bench
`timescale 1ns/1ps
module ebc_ctrl_assertions
    import ebc_pkg::*;
#(
    parameter int AW = ADDR_W
)
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic [ebc_pkg::REG_AW-1:0] reg_addr,
    input wire logic [ebc_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [ebc_pkg::DATA_W-1:0] reg_rdata,
    input wire logic abort_pin,
    input wire logic fatal_pin,
    input wire logic core_run,
    input wire logic core_start,
    input wire logic emulation_active_out
);
    import ebc_pkg::*;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    wire go_req = reg_wr && clk_en && reg_addr == OFF_CTRL && reg_wdata[CTRL_GO] && !core_run;
    sequence go_write;
        go_req;
    endsequence
    sequence started;
        core_start && emulation_active_out;
    endsequence
    a_go_starts: assert property (go_write |=> started)
        else $error("go did not start emulation");
    a_start_pulse: assert property (core_start |=> !core_start)
        else $error("start pulse too long");
    a_start_runs: assert property (started |-> core_run)
        else $error("start without run");
    a_idle_stays: assert property (!emulation_active_out && !go_req |=> !emulation_active_out)
        else $error("active rose without go");
    a_active_run: assert property (!core_run |-> !emulation_active_out)
        else $error("active while stopped");
    a_fatal_halts: assert property ($rose(fatal_pin) && emulation_active_out
        |-> ##[1:6] !emulation_active_out)
        else $error("fatal did not halt");
    a_abort_halts: assert property ($rose(abort_pin) && emulation_active_out
        |-> ##[1:12] !emulation_active_out)
        else $error("abort did not halt");
    a_unmapped_zero: assert property (reg_rd && clk_en && reg_addr > OFF_START_ADDR
        |=> reg_rdata == '0)
        else $error("unmapped read not zero");
endmodule

/* verif/tb_ebc_ctrl.sv */
// self-checking bench of the emulation control
// assumes the core model on the execution side
`timescale 1ns/1ps
module tb_ebc_ctrl;
    import ebc_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [REG_AW-1:0] reg_addr = '0;
    logic [DATA_W-1:0] reg_wdata = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic rd_d = 1'b0;
    logic clk_en = 1'b1;
    logic [2:0] pin_v = 3'h0;
    logic urdy = 1'b0;
    logic [DATA_W-1:0] reg_rdata, r;
    logic [19:0] exec_addr;
    logic [15:0] next_seg, next_ofs, core_seg, core_ofs;
    logic exec_strobe, instr_end, core_run, core_start, ready_use;
    logic emulation_active_out, trace_collect;
    logic [DATA_W-1:0] exp_q[$];
    string name_q[$];
    int mismatches = 0;
    int checks_done = 0;
    int seed = 32'h715D8CDE;
    initial
    begin
        forever #12.5 clk_sys = ~clk_sys;
    end
    ebc_ctrl u_ebc_ctrl (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .exec_addr(exec_addr), .exec_strobe(exec_strobe),
        .instr_end(instr_end), .next_seg(next_seg), .next_ofs(next_ofs),
        .abort_pin(pin_v[0]), .fatal_pin(pin_v[1]), .timeout_pin(pin_v[2]),
        .user_ready_pin(urdy), .core_run(core_run), .core_seg(core_seg),
        .core_ofs(core_ofs), .core_start(core_start), .ready_use(ready_use),
        .emulation_active_out(emulation_active_out), .trace_collect(trace_collect));
    ebc_core_model u_ebc_core_model (.clk_sys(clk_sys), .rst_n(rst_n), .core_run(core_run),
        .core_start(core_start), .core_seg(core_seg), .core_ofs(core_ofs),
        .exec_addr(exec_addr), .exec_strobe(exec_strobe), .instr_end(instr_end),
        .next_seg(next_seg), .next_ofs(next_ofs));
    task automatic check(input string n, input logic [DATA_W-1:0] s, input logic [DATA_W-1:0] e);
        checks_done++;
        if (s !== e)
        begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic wr(input logic [REG_AW-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [REG_AW-1:0] a, input logic [DATA_W-1:0] e, input string n);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        exp_q.push_back(e);
        name_q.push_back(n);
        @(posedge clk_sys);
        reg_rd <= 1'b0;
    endtask
    // read results compared in order
    always @(posedge clk_sys)
    begin
        rd_d <= reg_rd;
        if (rd_d === 1'b1 && exp_q.size() > 0)
            check(name_q.pop_front(), reg_rdata, exp_q.pop_front());
    end
    task automatic wait_halt(input int lim);
        int n;
        n = 0;
        while (emulation_active_out !== 1'b0 && n < lim)
        begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        if (emulation_active_out !== 1'b0)
        begin
            check("halt", 32'h1, 32'h0);
            close_out();
        end
    endtask
    task automatic go(input logic [DATA_W-1:0] bits, input logic [15:0] ofs);
        wr(OFF_CTRL, bits | (32'h1 << CTRL_GO));
        #1;
        check("active", emulation_active_out, 32'h1);
        check("start ofs", core_ofs, {16'h0000, ofs});
    endtask
    task automatic bp_run(input int s, input logic [19:0] v, input logic [19:0] c,
        input logic [15:0] ofs, input logic [15:0] e_ofs, input logic [DATA_W-1:0] e_st);
        wr(s ? OFF_BP1_VAL : OFF_BP0_VAL, {12'h000, v});
        wr(s ? OFF_BP1_CARE : OFF_BP0_CARE, {12'h000, c});
        wr(OFF_HALT_FACTOR, 32'h1 << s);
        wr(OFF_CODE_SEG, 32'h0);
        wr(OFF_INSTR_OFS, {16'h0000, ofs});
        go(32'h0, ofs);
        wait_halt(300);
        rd(OFF_INSTR_OFS, {16'h0000, e_ofs}, "halt ofs");
        rd(OFF_STATUS, e_st, "halt cause");
        $display("test slot %0d done", s);
    endtask
    task automatic halt_pin(input int i, input logic [DATA_W-1:0] e_st);
        wr(OFF_HALT_FACTOR, 32'h3);
        go((32'h1 << CTRL_FROM) | (32'h1 << CTRL_NO_HALT) | 32'h0FF00000, 16'h0FF0);
        rd(OFF_HALT_FACTOR, 32'h0, "no-halt");
        repeat (40) @(posedge clk_sys);
        check("past slots", emulation_active_out, 32'h1);
        pin_v[i] <= 1'b1;
        wait_halt(60);
        @(posedge clk_sys);
        pin_v[i] <= 1'b0;
        rd(OFF_STATUS, e_st, "pin cause");
        if (i == 0)
            rd(OFF_INSTR_OFS, {16'h0000, next_ofs}, "abort ofs");
        $display("test pin %0d done", i);
    endtask
    initial
    begin
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
        wr(OFF_HALT_FACTOR, 32'h3);
        wr(OFF_BP0_CARE, {12'h000, CARE_ALL});
        wr(OFF_CTRL, 32'h1 << CTRL_LOAD);
        rd(OFF_HALT_FACTOR, {30'h0, HF_NONE}, "init factor");
        rd(OFF_BP0_CARE, {12'h000, CARE_NONE}, "init care0");
        rd(OFF_BP1_CARE, {12'h000, CARE_NONE}, "init care1");
        wr(OFF_CODE_SEG, 32'h100);
        wr(OFF_INSTR_OFS, 32'h200);
        rd(OFF_START_ADDR, 32'h01200, "full addr");
        wr(OFF_BP1_VAL, 32'h01010);
        go(32'h000512A0, 16'h0200);
        wait_halt(300);
        rd(OFF_BP0_VAL, 32'h012A2, "short addr");
        rd(OFF_BP1_VAL, 32'h01010, "slot1 kept");
        rd(OFF_STATUS, 32'h8, "cmd cause");
        rd(4'hD, 32'h0, "unmapped");
        $display("test load done");
        r = $random(seed);
        bp_run(0, 20'h01000, 20'hFFF00, 16'h0F00 | (r[15:0] & 16'h00FE), 16'h1002, 32'h8);
        bp_run(1, 20'h01010, CARE_ALL, 16'h1004, 16'h1012, 32'h10);
        wr(OFF_CONFIG, 32'h1);
        halt_pin(0, 32'h2);
        halt_pin(1, 32'h4);
        halt_pin(2, 32'h20);
        r = $random(seed);
        @(posedge clk_sys);
        urdy <= r[0];
        wr(OFF_CONFIG, 32'h2);
        repeat (3) @(posedge clk_sys);
        #1;
        check("ready used", ready_use, {31'h0, r[0]});
        wr(OFF_CONFIG, 32'h0);
        repeat (3) @(posedge clk_sys);
        #1;
        check("ready off", ready_use, 32'h1);
        @(posedge clk_sys);
        clk_en <= 1'b0;
        wr(OFF_CONFIG, 32'h2);
        clk_en <= 1'b1;
        rd(OFF_CONFIG, 32'h0, "frozen cfg");
        $display("test ready done");
        repeat (4) @(posedge clk_sys);
        close_out();
    end
endmodule
bind ebc_ctrl ebc_ctrl_assertions #(.AW(AW)) u_ebc_ctrl_assertions (.clk_sys(clk_sys),
    .rst_n(rst_n), .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .abort_pin(abort_pin),
    .fatal_pin(fatal_pin), .core_run(core_run), .core_start(core_start),
    .emulation_active_out(emulation_active_out));
